/* rtl/bcr_defines.svh */
// Register offsets, field positions and opcodes for the cache and reservation controller
`ifndef BCR_DEFINES_SVH
`define BCR_DEFINES_SVH
`define BCR_OFF_CTRL 8'h00
`define BCR_OFF_CMD 8'h04
`define BCR_OFF_LBA 8'h08
`define BCR_OFF_LEN 8'h0c
`define BCR_OFF_VERDICT 8'h10
`define BCR_OFF_RES_SEL 8'h14
`define BCR_OFF_RES_ID 8'h18
`define BCR_OFF_RES_START 8'h1c
`define BCR_OFF_RES_END 8'h20
`define BCR_OFF_STATUS 8'h24
`define BCR_OFF_DEFER 8'h28
`define BCR_CTRL_GO 0
`define BCR_CTRL_WB 1
`define BCR_CTRL_PERINIT 2
`define BCR_CTRL_SYNC_DONE 3
`define BCR_CTRL_DEFER_CLR 4
`define BCR_CTRL_SYNC_ERR 5
`define BCR_NUM_RES 4
`define BCR_OP_TUR 8'h00
`define BCR_OP_REZERO 8'h01
`define BCR_OP_REQ_SENSE 8'h03
`define BCR_OP_FORMAT 8'h04
`define BCR_OP_REASSIGN 8'h07
`define BCR_OP_READ 8'h08
`define BCR_OP_WRITE 8'h0a
`define BCR_OP_SEEK 8'h0b
`define BCR_OP_INQUIRY 8'h12
`define BCR_OP_MODE_SEL 8'h15
`define BCR_OP_COPY 8'h18
`define BCR_OP_MODE_SENSE 8'h1a
`define BCR_OP_START_STOP 8'h1b
`define BCR_OP_RECV_DIAG 8'h1c
`define BCR_OP_SEND_DIAG 8'h1d
`define BCR_OP_PREVENT 8'h1e
`define BCR_OP_READ_CAP 8'h25
`define BCR_OP_VERIFY 8'h2f
`define BCR_OP_WRITE_VERIFY 8'h2e
`define BCR_OP_SET_LIMITS 8'h33
`define BCR_OP_PREFETCH 8'h34
`define BCR_OP_SYNC_CACHE 8'h35
`define BCR_OP_LOCK_CACHE 8'h36
`define BCR_OP_READ_DEFECT 8'h37
`define BCR_OP_COMPARE 8'h39
`define BCR_OP_COPY_VERIFY 8'h3a
`define BCR_OP_WRITE_BUF 8'h3b
`define BCR_OP_READ_BUF 8'h3c
`define BCR_OP_CHANGE_DEF 8'h40
`define BCR_OP_LOG_SEL 8'h4c
`define BCR_OP_LOG_SENSE 8'h4d
`define BCR_CMD_OP_LSB 0
`define BCR_CMD_INIT_LSB 8
`define BCR_CMD_RA_BIT 12
`define BCR_CMD_FMA_BIT 13
`define BCR_CMD_FLAG_BIT 14
`define BCR_CMD_AFFECT_BIT 15
`define BCR_CMD_DUNIT_BIT 16
`define BCR_CMD_LOCK_BIT 17
`define BCR_RESP_OKAY 2'b00
`define BCR_RESP_SLVERR 2'b10
`endif

/* rtl/bcr_pkg.sv */
// Types shared by the cache and reservation controller
package bcr_pkg;
	typedef enum logic [1:0] {
		BCR_IDLE,
		BCR_FLUSH,
		BCR_DONE
	} bcr_state_e;
	typedef struct packed {
		logic [3:0] id;
		logic [31:0] start;
		logic [31:0] last;
		logic valid;
	} bcr_res_s;
	typedef struct packed {
		bcr_state_e st;
		bcr_res_s [3:0] res;
		logic [31:0] cmd;
		logic [31:0] lba;
		logic [31:0] len;
		logic [1:0] res_sel;
		logic wb;
		logic perinit;
		logic defer;
		logic conflict;
		logic [3:0] verdict;
		logic cmd_done;
		logic awdone;
		logic wdone;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic flush_req;
	} bcr_state_s;
endpackage

/* rtl/bcr_ctrl.sv */
// Command policy: cache use hints and extent reservation conflict checks
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "bcr_defines.svh"
module bcr_ctrl import bcr_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic flush_req
);
	// All state lives here
	bcr_state_s q_r;
	// Next state
	bcr_state_s d_nxt;
	// Handshake terms
	logic aw_fire, w_fire, ar_fire;
	// Write address/data combined
	logic wr_go;
	logic [31:0] wr_val;
	logic [7:0] wr_addr;

	// True when [a,b] overlaps any reservation not owned by id
	function automatic logic foreign_hit(input bcr_res_s [3:0] t, input logic [3:0] id,
			input logic [31:0] a, input logic [31:0] b);
		logic h;
		h = 1'b0;
		for (int i = 0; i < `BCR_NUM_RES; i++) begin
			if (t[i].valid && t[i].id != id && a <= t[i].last && b >= t[i].start) begin
				h = 1'b1;
			end
		end
		return h;
	endfunction

	// True when any other initiator holds any reservation
	function automatic logic foreign_any(input bcr_res_s [3:0] t, input logic [3:0] id);
		logic h;
		h = 1'b0;
		for (int i = 0; i < `BCR_NUM_RES; i++) begin
			if (t[i].valid && t[i].id != id) begin
				h = 1'b1;
			end
		end
		return h;
	endfunction

	// Conflict decision for one command against the table
	function automatic logic decide(input bcr_res_s [3:0] t, input logic [31:0] c,
			input logic [31:0] a, input logic [31:0] n, input logic perinit);
		logic [7:0] op;
		logic [3:0] id;
		logic [31:0] b;
		logic hit;
		logic any;
		op = c[`BCR_CMD_OP_LSB +: 8];
		id = c[`BCR_CMD_INIT_LSB +: 4];
		b = a + ((n == 32'h0000_0000) ? 32'h0000_0000 : n - 32'h0000_0001);
		hit = foreign_hit(t, id, a, b);
		any = foreign_any(t, id);
		case (op)
			`BCR_OP_INQUIRY, `BCR_OP_REQ_SENSE: decide = 1'b0;
			`BCR_OP_LOG_SEL, `BCR_OP_LOG_SENSE, `BCR_OP_MODE_SENSE, `BCR_OP_TUR,
			`BCR_OP_READ_BUF, `BCR_OP_WRITE_BUF, `BCR_OP_READ_DEFECT: decide = 1'b0;
			// capacity clear flag free, else treated as whole-unit
			`BCR_OP_READ_CAP: decide = c[`BCR_CMD_FLAG_BIT] & any;
			`BCR_OP_FORMAT, `BCR_OP_REZERO, `BCR_OP_START_STOP: decide = any;
			`BCR_OP_PREVENT: decide = c[`BCR_CMD_FLAG_BIT] & any;
			`BCR_OP_MODE_SEL: decide = any & c[`BCR_CMD_AFFECT_BIT] & ~perinit;
			`BCR_OP_SEND_DIAG, `BCR_OP_RECV_DIAG: decide = any & c[`BCR_CMD_AFFECT_BIT];
			`BCR_OP_CHANGE_DEF: decide = any & ~perinit;
			`BCR_OP_COMPARE, `BCR_OP_COPY, `BCR_OP_COPY_VERIFY:
				decide = hit | (c[`BCR_CMD_DUNIT_BIT] & any);
			`BCR_OP_SEEK, `BCR_OP_LOCK_CACHE, `BCR_OP_PREFETCH, `BCR_OP_SYNC_CACHE,
			`BCR_OP_REASSIGN, `BCR_OP_SET_LIMITS, `BCR_OP_READ, `BCR_OP_WRITE,
			`BCR_OP_VERIFY, `BCR_OP_WRITE_VERIFY: decide = hit;
			default: decide = any;
		endcase
	endfunction

	// Cache policy verdict bits: [0] keep residents [1] medium [2] bypass [3] lock
	function automatic logic [3:0] policy(input logic [31:0] c, input logic wb);
		logic [7:0] op;
		logic ra, fma, vfy;
		op = c[`BCR_CMD_OP_LSB +: 8];
		ra = c[`BCR_CMD_RA_BIT];
		fma = c[`BCR_CMD_FMA_BIT];
		vfy = (op == `BCR_OP_VERIFY) || (op == `BCR_OP_WRITE_VERIFY);
		policy = 4'h0;
		policy[0] = ra;
		// medium access forced; write-through unless write-back
		policy[1] = fma | vfy | ((op == `BCR_OP_WRITE) & ~wb);
		policy[2] = ra & (fma | vfy);
		// lock only by lock command; prefetch leaves unlocked
		policy[3] = (op == `BCR_OP_LOCK_CACHE) & c[`BCR_CMD_LOCK_BIT];
	endfunction

	assign aw_fire = s_axi_awvalid & ~q_r.awdone & ~q_r.bvalid;
	assign w_fire = s_axi_wvalid & ~q_r.wdone & ~q_r.bvalid;
	assign ar_fire = s_axi_arvalid & ~q_r.rvalid;
	assign wr_go = (q_r.awdone | aw_fire) & (q_r.wdone | w_fire);
	assign wr_addr = q_r.awdone ? q_r.awaddr : s_axi_awaddr;
	assign wr_val = q_r.wdone ? q_r.wdata : s_axi_wdata;

	// Next-state logic: bus slave, table and command sequencing
	always_comb begin
		logic [31:0] rd;
		logic mapped;
		logic [7:0] op;
		rd = 32'h0000_0000;
		mapped = 1'b1;
		op = q_r.cmd[7:0];
		d_nxt = q_r;
		// Write channel capture
		if (aw_fire) begin
			d_nxt.awdone = 1'b1;
			d_nxt.awaddr = s_axi_awaddr;
		end
		if (w_fire) begin
			d_nxt.wdone = 1'b1;
			d_nxt.wdata = s_axi_wdata;
		end
		if (q_r.bvalid && s_axi_bready) begin
			d_nxt.bvalid = 1'b0;
		end
		// Sequencer
		case (q_r.st)
			BCR_IDLE: begin
			end
			BCR_FLUSH: begin
			end
			BCR_DONE: d_nxt.st = BCR_IDLE;
			default: d_nxt.st = BCR_IDLE;
		endcase
		// Register write after both halves taken
		if (wr_go) begin
			d_nxt.awdone = 1'b0;
			d_nxt.wdone = 1'b0;
			d_nxt.bvalid = 1'b1;
			d_nxt.bresp = `BCR_RESP_OKAY;
			case (wr_addr)
				`BCR_OFF_CTRL: begin
					d_nxt.wb = wr_val[`BCR_CTRL_WB];
					d_nxt.perinit = wr_val[`BCR_CTRL_PERINIT];
					if (wr_val[`BCR_CTRL_GO] && q_r.st == BCR_IDLE) begin
						d_nxt.conflict = decide(q_r.res, q_r.cmd, q_r.lba, q_r.len,
							wr_val[`BCR_CTRL_PERINIT]);
						d_nxt.verdict = policy(q_r.cmd, wr_val[`BCR_CTRL_WB]);
						d_nxt.cmd_done = 1'b0;
						// flush before verify or on synchronize
						if (!d_nxt.conflict && (op == `BCR_OP_VERIFY ||
								op == `BCR_OP_WRITE_VERIFY || op == `BCR_OP_SYNC_CACHE)) begin
							d_nxt.st = BCR_FLUSH;
							d_nxt.flush_req = 1'b1;
						end else begin
							d_nxt.st = BCR_DONE;
							d_nxt.cmd_done = 1'b1;
						end
					end
					if (wr_val[`BCR_CTRL_SYNC_DONE] && q_r.st == BCR_FLUSH) begin
						d_nxt.flush_req = 1'b0;
						d_nxt.cmd_done = 1'b1;
						d_nxt.st = BCR_DONE;
						// flush error reported on this command
						if (wr_val[`BCR_CTRL_SYNC_ERR]) begin
							d_nxt.bresp = `BCR_RESP_SLVERR;
						end
					end
					if (wr_val[`BCR_CTRL_DEFER_CLR]) begin
						d_nxt.defer = 1'b0;
					end
				end
				`BCR_OFF_CMD: d_nxt.cmd = wr_val;
				`BCR_OFF_LBA: d_nxt.lba = wr_val;
				`BCR_OFF_LEN: d_nxt.len = wr_val;
				`BCR_OFF_RES_SEL: d_nxt.res_sel = wr_val[1:0];
				`BCR_OFF_RES_ID: begin
					d_nxt.res[q_r.res_sel].id = wr_val[3:0];
					d_nxt.res[q_r.res_sel].valid = wr_val[31];
				end
				`BCR_OFF_RES_START: d_nxt.res[q_r.res_sel].start = wr_val;
				`BCR_OFF_RES_END: d_nxt.res[q_r.res_sel].last = wr_val;
				`BCR_OFF_DEFER: begin
					// medium write error logged for a later command
					if (wr_val[0]) begin
						d_nxt.defer = 1'b1;
					end
				end
				default: d_nxt.bresp = `BCR_RESP_SLVERR;
			endcase
		end
		// Read channel
		if (q_r.rvalid && s_axi_rready) begin
			d_nxt.rvalid = 1'b0;
		end
		if (ar_fire) begin
			case (s_axi_araddr)
				`BCR_OFF_CTRL: rd = {29'h0, q_r.perinit, q_r.wb, 1'b0};
				`BCR_OFF_CMD: rd = q_r.cmd;
				`BCR_OFF_LBA: rd = q_r.lba;
				`BCR_OFF_LEN: rd = q_r.len;
				`BCR_OFF_VERDICT: rd = {27'h0, q_r.conflict, q_r.verdict};
				`BCR_OFF_RES_SEL: rd = {30'h0, q_r.res_sel};
				`BCR_OFF_RES_ID: rd = {q_r.res[q_r.res_sel].valid, 27'h0,
					q_r.res[q_r.res_sel].id};
				`BCR_OFF_RES_START: rd = q_r.res[q_r.res_sel].start;
				`BCR_OFF_RES_END: rd = q_r.res[q_r.res_sel].last;
				`BCR_OFF_STATUS: rd = {28'h0, q_r.flush_req, q_r.cmd_done,
					q_r.st == BCR_FLUSH, q_r.st != BCR_IDLE};
				`BCR_OFF_DEFER: rd = {31'h0, q_r.defer};
				default: mapped = 1'b0;
			endcase
			d_nxt.rvalid = 1'b1;
			d_nxt.rdata = rd;
			d_nxt.rresp = mapped ? `BCR_RESP_OKAY : `BCR_RESP_SLVERR;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			q_r <= '0;
		end else begin
			q_r <= d_nxt;
		end
	end

	// Outputs straight from flops; ready offered while channel slot free
	assign s_axi_awready = ~q_r.awdone & ~q_r.bvalid;
	assign s_axi_wready = ~q_r.wdone & ~q_r.bvalid;
	assign s_axi_arready = ~q_r.rvalid;
	assign s_axi_bvalid = q_r.bvalid;
	assign s_axi_bresp = q_r.bresp;
	assign s_axi_rvalid = q_r.rvalid;
	assign s_axi_rdata = q_r.rdata;
	assign s_axi_rresp = q_r.rresp;
	assign flush_req = q_r.flush_req;

	// Helper: foreign overlap of the staged command
	logic stage_hit;
	assign stage_hit = foreign_hit(q_r.res, q_r.cmd[11:8], q_r.lba,
		q_r.lba + ((q_r.len == 32'h0) ? 32'h0 : q_r.len - 32'h1));

	// Go strobe taken this cycle while idle; a plain term so it joins other terms
	logic go_now;
	assign go_now = wr_go && wr_addr == `BCR_OFF_CTRL && wr_val[`BCR_CTRL_GO] &&
		q_r.st == BCR_IDLE;
	// Opcode of the staged command
	logic [7:0] stage_op;
	assign stage_op = q_r.cmd[`BCR_CMD_OP_LSB +: 8];
	// Done strobe from software while a flush is pending
	sequence s_sync_wr;
		q_r.st == BCR_FLUSH && wr_go && wr_addr == `BCR_OFF_CTRL &&
			wr_val[`BCR_CTRL_SYNC_DONE];
	endsequence
	// Command closed and request dropped, then back to idle
	sequence s_closed;
		q_r.cmd_done && !q_r.flush_req && q_r.st == BCR_DONE ##1 q_r.st == BCR_IDLE;
	endsequence

	a_inquiry_free: assert property (@(posedge clk) disable iff (rst)
		go_now && (q_r.cmd[7:0] == `BCR_OP_INQUIRY) |=> !q_r.conflict)
		else $error("inquiry blocked");
	a_read_hit_conf: assert property (@(posedge clk) disable iff (rst)
		go_now && q_r.cmd[7:0] == `BCR_OP_READ && stage_hit |=> q_r.conflict)
		else $error("read overlap missed");
	a_format_conf: assert property (@(posedge clk) disable iff (rst)
		go_now && q_r.cmd[7:0] == `BCR_OP_FORMAT |=>
		q_r.conflict == $past(foreign_any(q_r.res, q_r.cmd[11:8])))
		else $error("format conflict wrong");
	a_bypass_both: assert property (@(posedge clk) disable iff (rst)
		go_now && q_r.cmd[12] && q_r.cmd[13] |=> q_r.verdict[2] && q_r.verdict[1])
		else $error("bypass missing");
	a_fma_medium: assert property (@(posedge clk) disable iff (rst)
		go_now && q_r.cmd[13] |=> q_r.verdict[1])
		else $error("forced access lost");
	a_advice_keep: assert property (@(posedge clk) disable iff (rst)
		go_now && q_r.cmd[12] |=> q_r.verdict[0])
		else $error("advice lost");
	a_verify_flush: assert property (@(posedge clk) disable iff (rst)
		go_now && q_r.cmd[7:0] == `BCR_OP_VERIFY && !stage_hit |=>
		q_r.flush_req && !q_r.cmd_done)
		else $error("verify without flush");
	a_flush_hold: assert property (@(posedge clk) disable iff (rst)
		q_r.st == BCR_FLUSH && !(wr_go && wr_addr == `BCR_OFF_CTRL && wr_val[3]) |=>
		q_r.st == BCR_FLUSH && !q_r.cmd_done)
		else $error("flush ended early");
	a_b_follows: assert property (@(posedge clk) disable iff (rst)
		wr_go |=> q_r.bvalid)
		else $error("no write response");
	a_flush_close: assert property (@(posedge clk) disable iff (rst)
		s_sync_wr |=> s_closed)
		else $error("flush did not close");
	a_info_free: assert property (@(posedge clk) disable iff (rst)
		go_now && (stage_op == `BCR_OP_LOG_SEL || stage_op == `BCR_OP_LOG_SENSE ||
		stage_op == `BCR_OP_MODE_SENSE || stage_op == `BCR_OP_TUR ||
		stage_op == `BCR_OP_READ_BUF || stage_op == `BCR_OP_WRITE_BUF ||
		stage_op == `BCR_OP_READ_DEFECT) |=> !q_r.conflict)
		else $error("info command blocked");
	a_prevent_free: assert property (@(posedge clk) disable iff (rst)
		go_now && stage_op == `BCR_OP_PREVENT && !q_r.cmd[`BCR_CMD_FLAG_BIT] |=>
		!q_r.conflict)
		else $error("allow removal blocked");
	a_range_conf: assert property (@(posedge clk) disable iff (rst)
		go_now && stage_hit && (stage_op == `BCR_OP_SEEK ||
		stage_op == `BCR_OP_LOCK_CACHE || stage_op == `BCR_OP_PREFETCH ||
		stage_op == `BCR_OP_SYNC_CACHE) |=> q_r.conflict)
		else $error("cache command overlap missed");
	a_fix_conf: assert property (@(posedge clk) disable iff (rst)
		go_now && stage_hit && (stage_op == `BCR_OP_REASSIGN ||
		stage_op == `BCR_OP_SET_LIMITS) |=> q_r.conflict)
		else $error("reassign or limits overlap missed");
	a_dest_unit: assert property (@(posedge clk) disable iff (rst)
		go_now && stage_op == `BCR_OP_COPY && q_r.cmd[`BCR_CMD_DUNIT_BIT] &&
		foreign_any(q_r.res, q_r.cmd[11:8]) |=> q_r.conflict)
		else $error("destination unit not checked");
	a_affect_free: assert property (@(posedge clk) disable iff (rst)
		go_now && !q_r.cmd[`BCR_CMD_AFFECT_BIT] &&
		(stage_op == `BCR_OP_MODE_SEL || stage_op == `BCR_OP_SEND_DIAG ||
		stage_op == `BCR_OP_RECV_DIAG) |=> !q_r.conflict)
		else $error("harmless setup blocked");
	a_chgdef_free: assert property (@(posedge clk) disable iff (rst)
		go_now && stage_op == `BCR_OP_CHANGE_DEF && wr_val[`BCR_CTRL_PERINIT] |=>
		!q_r.conflict)
		else $error("per initiator definition blocked");
	a_wb_early: assert property (@(posedge clk) disable iff (rst)
		go_now && stage_op == `BCR_OP_WRITE && !q_r.cmd[`BCR_CMD_FMA_BIT] &&
		wr_val[`BCR_CTRL_WB] |=> !q_r.verdict[1] && q_r.cmd_done)
		else $error("write back not early");
	a_lock_set: assert property (@(posedge clk) disable iff (rst)
		go_now && stage_op == `BCR_OP_LOCK_CACHE && q_r.cmd[`BCR_CMD_LOCK_BIT] |=>
		q_r.verdict[3])
		else $error("lock lost");
	a_prefetch_free: assert property (@(posedge clk) disable iff (rst)
		go_now && stage_op == `BCR_OP_PREFETCH |=> !q_r.verdict[3])
		else $error("prefetch locked blocks");
endmodule

/* sim/bcr_medium_model.sv */
// Medium model: answers a flush request after a fixed write time
`timescale 1ns/10ps
module bcr_medium_model #(parameter int DELAY = 4) (
	input wire logic clk,
	input wire logic rst,
	input wire logic flush_req,
	output logic flush_ack
);
	// Cycles spent writing cached data out
	int cnt;
	// ack only once the range is on the medium
	always_ff @(posedge clk) begin
		if (rst || !flush_req) begin
			cnt <= 0;
			flush_ack <= 1'h0;
		end else if (cnt == DELAY) begin
			flush_ack <= 1'h1;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule

/* sim/tb_block_cache_reservation_ctrl.sv */
// Bench for the cache and reservation controller
`timescale 1ns/10ps
`include "bcr_defines.svh"
module tb_block_cache_reservation_ctrl;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 1'h0;
	logic s_axi_wvalid = 1'h0;
	logic s_axi_arvalid = 1'h0;
	// Responses always accepted at once
	logic s_axi_bready = 1'h1;
	logic s_axi_rready = 1'h1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic flush_req, flush_ack;
	// Scratch for read data and response codes
	logic [31:0] d;
	logic [1:0] r;
	// Commands that must wait for a medium flush: verify, write-verify, synchronize
	logic [7:0] flush_ops [3] = '{8'h2f, 8'h2e, 8'h35};
	int fail_count = 0;
	int comparisons = 0;
	bcr_ctrl bcr_ctrl_inst(.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .flush_req(flush_req));
	bcr_medium_model #(.DELAY(5)) bcr_medium_model_inst(.clk(clk), .rst(rst),
		.flush_req(flush_req), .flush_ack(flush_ack));
	// 25 MHz clock
	initial begin
		forever #20 clk = ~clk;
	end
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Write: address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		forever begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) begin
				rs = s_axi_bresp;
				break;
			end
		end
	endtask
	// Read one word
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		forever begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) begin
				v = s_axi_rdata;
				rs = s_axi_rresp;
				break;
			end
		end
	endtask
	// Issue one command and fetch its verdict
	task automatic go(input logic [31:0] c, input logic [31:0] lba, input logic [31:0] n,
		input logic [31:0] ctl);
		wr(`BCR_OFF_CMD, c, r);
		wr(`BCR_OFF_LBA, lba, r);
		wr(`BCR_OFF_LEN, n, r);
		wr(`BCR_OFF_CTRL, ctl, r);
		rd(`BCR_OFF_VERDICT, d, r);
	endtask
	// Cache policy bits of an owner command at block 150
	task automatic pol(input logic [31:0] c, input logic [31:0] ctl, input logic [31:0] m,
		input logic [31:0] e);
		go(c, 32'h96, 32'h0, ctl);
		chk(d & m, e);
	endtask
	// Conflict bit of a command
	task automatic con(input logic [31:0] c, input logic [31:0] lba, input logic [31:0] n,
		input logic [31:0] ctl, input logic [31:0] e);
		go(c, lba, n, ctl);
		chk(d & 32'h10, e);
	endtask
	// Single exit: counts then verdict
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Watchdog, far beyond the several hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		complete_run();
	end
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		rd(`BCR_OFF_VERDICT, d, r);
		chk(d, 32'h0);
		rd(`BCR_OFF_STATUS, d, r);
		chk(d, 32'h0);
		// Unmapped place answers with an error and zero data
		rd(8'h3c, d, r);
		chk(d, 32'h0);
		chk(r, 32'h2);
		$display("Test reset done");
		// owner reserves blocks 100 to 199 before caching writes
		wr(`BCR_OFF_RES_SEL, 32'h0, r);
		wr(`BCR_OFF_RES_ID, 32'h80000001, r);
		wr(`BCR_OFF_RES_START, 32'h64, r);
		wr(`BCR_OFF_RES_END, 32'hc7, r);
		rd(`BCR_OFF_RES_END, d, r);
		chk(d, 32'hc7);
		pol(32'h110a, 32'h3, 32'h1, 32'h1);
		pol(32'h1108, 32'h1, 32'h1, 32'h1);
		pol(32'h210a, 32'h3, 32'h2, 32'h2);
		pol(32'h2108, 32'h1, 32'h2, 32'h2);
		pol(32'h3108, 32'h1, 32'h4, 32'h4);
		pol(32'h310a, 32'h3, 32'h4, 32'h4);
		pol(32'h010a, 32'h3, 32'h2, 32'h0);
		pol(32'h20136, 32'h1, 32'h8, 32'h8);
		pol(32'h00136, 32'h1, 32'h8, 32'h0);
		pol(32'h0134, 32'h1, 32'h8, 32'h0);
		$display("Test cache policy done");
		con(32'h0208, 32'h96, 32'h0, 32'h1, 32'h10);
		con(32'h0108, 32'h96, 32'h0, 32'h1, 32'h0);
		con(32'h0208, 32'hc8, 32'h0, 32'h1, 32'h0);
		con(32'h0208, 32'h62, 32'h2, 32'h1, 32'h0);
		con(32'h0208, 32'h63, 32'h2, 32'h1, 32'h10);
		con(32'h0204, 32'h0, 32'h0, 32'h1, 32'h10);
		con(32'h0201, 32'h0, 32'h0, 32'h1, 32'h10);
		con(32'h021b, 32'h0, 32'h0, 32'h1, 32'h10);
		con(32'h421e, 32'h0, 32'h0, 32'h1, 32'h10);
		con(32'h0212, 32'h96, 32'h0, 32'h1, 32'h0);
		con(32'h0203, 32'h96, 32'h0, 32'h1, 32'h0);
		con(32'h024c, 32'h96, 32'h0, 32'h1, 32'h0);
		con(32'h024d, 32'h96, 32'h0, 32'h1, 32'h0);
		con(32'h021a, 32'h96, 32'h0, 32'h1, 32'h0);
		con(32'h0200, 32'h96, 32'h0, 32'h1, 32'h0);
		con(32'h023c, 32'h96, 32'h0, 32'h1, 32'h0);
		con(32'h023b, 32'h96, 32'h0, 32'h1, 32'h0);
		con(32'h0237, 32'h96, 32'h0, 32'h1, 32'h0);
		con(32'h0225, 32'h96, 32'h0, 32'h1, 32'h0);
		con(32'h020b, 32'h96, 32'h0, 32'h1, 32'h10);
		con(32'h0236, 32'h96, 32'h0, 32'h1, 32'h10);
		con(32'h0234, 32'h96, 32'h0, 32'h1, 32'h10);
		con(32'h0235, 32'h96, 32'h0, 32'h1, 32'h10);
		con(32'h0239, 32'h96, 32'h0, 32'h1, 32'h10);
		con(32'h0218, 32'h96, 32'h0, 32'h1, 32'h10);
		con(32'h1023a, 32'h32, 32'h0, 32'h1, 32'h10);
		con(32'h8215, 32'h0, 32'h0, 32'h1, 32'h10);
		con(32'h0215, 32'h0, 32'h0, 32'h1, 32'h0);
		con(32'h8215, 32'h0, 32'h0, 32'h5, 32'h0);
		con(32'h821d, 32'h0, 32'h0, 32'h1, 32'h10);
		con(32'h021c, 32'h0, 32'h0, 32'h1, 32'h0);
		con(32'h0207, 32'h96, 32'h0, 32'h1, 32'h10);
		con(32'h0233, 32'h96, 32'h0, 32'h1, 32'h10);
		con(32'h0240, 32'h0, 32'h0, 32'h1, 32'h10);
		con(32'h0240, 32'h0, 32'h0, 32'h5, 32'h0);
		con(32'h021e, 32'h0, 32'h0, 32'h1, 32'h0);
		con(32'h4225, 32'h96, 32'h0, 32'h1, 32'h10);
		con(32'h02ff, 32'h0, 32'h0, 32'h1, 32'h10);
		con(32'h020a, 32'h96, 32'h0, 32'h1, 32'h10);
		con(32'h0218, 32'h32, 32'h0, 32'h1, 32'h0);
		$display("Test reservations done");
		// Verify, write-verify, then a synchronize that meets a medium error
		for (int i = 0; i < 3; i++) begin
			go({24'h1, flush_ops[i]}, 32'h96, 32'h0, 32'h1);
			// Only the verify kinds force the medium bit; synchronize leaves it clear
			chk(d & 32'h2, (i == 2) ? 32'h0 : 32'h2);
			chk(flush_req, 32'h1);
			// Still flushing and not done before the medium answers
			rd(`BCR_OFF_STATUS, d, r);
			chk(d, 32'hb);
			for (int n = 0; n < 100 && flush_ack !== 1'h1; n++) @(posedge clk);
			chk(flush_ack, 32'h1);
			wr(`BCR_OFF_CTRL, (i == 2) ? 32'h28 : 32'h8, r);
			chk(r, (i == 2) ? 32'h2 : 32'h0);
			rd(`BCR_OFF_STATUS, d, r);
			chk(d, 32'h4);
		end
		// Deferred write error is latched and then cleared
		wr(`BCR_OFF_DEFER, 32'h1, r);
		rd(`BCR_OFF_DEFER, d, r);
		chk(d & 32'h1, 32'h1);
		wr(`BCR_OFF_CTRL, 32'h10, r);
		rd(`BCR_OFF_DEFER, d, r);
		chk(d & 32'h1, 32'h0);
		// Mid-run reset empties the table and drops a latched error
		wr(`BCR_OFF_DEFER, 32'h1, r);
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		rd(`BCR_OFF_DEFER, d, r);
		chk(d, 32'h0);
		rd(`BCR_OFF_RES_ID, d, r);
		chk(d, 32'h0);
		con(32'h0208, 32'h96, 32'h0, 32'h1, 32'h0);
		$display("Test flush and defer done");
		complete_run();
	end
endmodule
